// ==== rtl/fll_defs.svh ====
// offsets, field positions, reset values and timing counts of the clock source unit
// assumes a 20 MHz system clock and a 32-bit avalon-mm register port
`ifndef FLL_DEFS_SVH
`define FLL_DEFS_SVH
`define OFS_FIRST_CTRL 4'h0
`define OFS_SECOND_CTRL 4'h4
`define OFS_TRIM 4'h8
`define OFS_STATUS_CTRL 4'hc
`define RST_FIRST_CTRL 8'h04
`define RST_SECOND_CTRL 8'h40
`define RST_TRIM 8'h80
`define RST_FINE_TRIM 1'b0
`define STAT_FINE_TRIM 0
`define STAT_OSC_READY 1
`define STAT_CLK_STATE 2
`define STAT_LOCKED 4
`define STAT_FF_VALID 5
`define CLK_MHZ 20
`define IRST_US 60
`define IRST_CYCLES (`IRST_US * `CLK_MHZ)
`define ACQUIRE_US 1000
`define ACQUIRE_CYCLES (`ACQUIRE_US * `CLK_MHZ)
`define FLL_MULT_SHIFT 9
`define OSC_INIT_EDGES 8'h40
`define SWITCH_TICKS 3'h4
`define FF_BUS_DIV_OFFSET 3'h2
`endif

// ==== rtl/fll_pkg.sv ====
// types shared by the clock source unit
// assumes nothing from fll_defs.svh; field widths are written as literals
package fll_pkg;
    typedef logic [1:0] clk_sel_t;
    typedef struct packed {
        clk_sel_t clock_select_field;
        logic [2:0] reference_divider;
        logic internal_reference_select;
        logic internal_ref_output_enable;
        logic internal_ref_stop_enable;
    } first_ctrl_t;
    typedef struct packed {
        logic [1:0] bus_divider;
        logic range_sel;
        logic high_gain;
        logic fll_power_down_bit;
        logic external_oscillator_select;
        logic external_ref_output_enable;
        logic external_ref_stop_enable;
    } second_ctrl_t;
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avl_req_t;
    typedef enum logic [0:0] {sw_idle, sw_wait} switch_state_t;
endpackage

// ==== rtl/fll_clock_source_control.sv ====
// clock source unit: reference selection, fll lock model, fixed-frequency clock and mode switching
// assumes clk at 20 MHz, ext_ref_in and bdm_active asynchronous pins, an avalon-mm master on the bus
`include "fll_defs.svh"
module fll_clock_source_control #(
    parameter int ACQUIRE_CYCLES = `ACQUIRE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire fll_pkg::avl_req_t avl_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_ref_in,
    input wire logic bdm_active,
    output logic fixed_freq_clock,
    output logic fixed_freq_valid,
    output fll_pkg::clk_sel_t main_clock_source,
    output logic [1:0] bus_divider,
    output logic fll_enabled,
    output logic fll_locked,
    output logic [15:0] dco_period,
    output logic internal_ref_running,
    output logic external_ref_running
);
    import fll_pkg::*;

    first_ctrl_t first_control_reg;
    second_ctrl_t second_control_reg;
    logic [7:0] trim_reg;
    logic fine_trim_bit;
    logic oscillator_ready_flag;
    clk_sel_t clock_state_field;
    logic ack;
    logic sel_first, sel_second, sel_trim, sel_status;
    logic ext_meta, ext_sync, ext_prev, bdm_meta, bdm_sync;
    logic ext_tick, irc_tick, ref_tick, filter_tick;
    logic [8:0] irc_cnt;
    logic [11:0] irst_cnt;
    logic irc_stable;
    logic [7:0] osc_cnt;
    logic [6:0] div_cnt;
    logic [15:0] period_cnt;
    logic [31:0] lock_cnt;
    logic [3:0] ref_cfg_prev;
    switch_state_t sw_state;
    clk_sel_t sw_target;
    logic [2:0] sw_cnt;
    logic target_tick, target_avail;

    // address decode over word offsets
    assign sel_first = avl_req.address == `OFS_FIRST_CTRL;
    assign sel_second = avl_req.address == `OFS_SECOND_CTRL;
    assign sel_trim = avl_req.address == `OFS_TRIM;
    assign sel_status = avl_req.address == `OFS_STATUS_CTRL;
    assign avs_waitrequest = (avl_req.read | avl_req.write) & ~ack;

    // one wait state: data captured first cycle, released second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avl_req.read | avl_req.write) & ~ack;
        end
    end

    // read data registered in the wait cycle, unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avl_req.read && !ack) begin
            avs_readdata <= 32'h0000_0000;
            if (sel_first) avs_readdata[7:0] <= first_control_reg;
            if (sel_second) avs_readdata[7:0] <= second_control_reg;
            if (sel_trim) avs_readdata[7:0] <= trim_reg;
            if (sel_status) begin
                avs_readdata[`STAT_FINE_TRIM] <= fine_trim_bit;
                avs_readdata[`STAT_OSC_READY] <= oscillator_ready_flag;
                avs_readdata[`STAT_CLK_STATE +: 2] <= clock_state_field;
                avs_readdata[`STAT_LOCKED] <= fll_locked;
                avs_readdata[`STAT_FF_VALID] <= fixed_freq_valid;
            end
        end
    end

    // control registers; writes take effect at the ack edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_control_reg <= `RST_FIRST_CTRL;
            second_control_reg <= `RST_SECOND_CTRL;
            trim_reg <= `RST_TRIM;
            fine_trim_bit <= `RST_FINE_TRIM;
        end else if (avl_req.write && ack) begin
            if (sel_first) first_control_reg <= avl_req.writedata[7:0];
            if (sel_second) second_control_reg <= avl_req.writedata[7:0];
            if (sel_trim) trim_reg <= avl_req.writedata[7:0];
            if (sel_status) fine_trim_bit <= avl_req.writedata[`STAT_FINE_TRIM];
        end
    end

    // pin synchronisers and external edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            bdm_meta <= 1'b0;
            bdm_sync <= 1'b0;
        end else begin
            ext_meta <= ext_ref_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            bdm_meta <= bdm_active;
            bdm_sync <= bdm_meta;
        end
    end

    // reference enables: kept running by the output enables across modes
    assign internal_ref_running = first_control_reg.internal_reference_select
        | (first_control_reg.clock_select_field == 2'b01)
        | first_control_reg.internal_ref_output_enable;
    assign external_ref_running = ~first_control_reg.internal_reference_select
        | (first_control_reg.clock_select_field == 2'b10)
        | second_control_reg.external_ref_output_enable;
    assign ext_tick = external_ref_running & ext_sync & ~ext_prev;

    // internal reference: larger trim gives a longer period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irc_cnt <= 9'h000;
        end else if (!internal_ref_running || irc_cnt >= {trim_reg, fine_trim_bit}) begin
            irc_cnt <= 9'h000;
        end else begin
            irc_cnt <= irc_cnt + 9'h001;
        end
    end
    assign irc_tick = internal_ref_running & irc_stable & (irc_cnt >= {trim_reg, fine_trim_bit});

    // internal reference startup timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irst_cnt <= 12'h000;
            irc_stable <= 1'b0;
        end else if (!internal_ref_running) begin
            irst_cnt <= 12'h000;
            irc_stable <= 1'b0;
        end else if (irst_cnt == 12'(`IRST_CYCLES - 1)) begin
            irc_stable <= 1'b1;
        end else begin
            irst_cnt <= irst_cnt + 12'h001;
        end
    end

    // oscillator init: count external edges; deselect or power loss clears count and flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt <= 8'h00;
            oscillator_ready_flag <= 1'b0;
        end else if (second_control_reg.external_oscillator_select && external_ref_running) begin
            if (osc_cnt == `OSC_INIT_EDGES) begin
                oscillator_ready_flag <= 1'b1;
            end else if (ext_tick) begin
                osc_cnt <= osc_cnt + 8'h01;
            end
        end else begin
            osc_cnt <= 8'h00;
            oscillator_ready_flag <= 1'b0;
        end
    end

    // fll reference chosen by internal select, then the reference divider
    assign ref_tick = first_control_reg.internal_reference_select ? irc_tick : ext_tick;
    assign filter_tick = ref_tick && div_cnt >= 7'((8'h01 << first_control_reg.reference_divider) - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 7'h00;
        end else if (filter_tick) begin
            div_cnt <= 7'h00;
        end else if (ref_tick) begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // fixed frequency clock toggles on every divided reference tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fixed_freq_clock <= 1'b0;
        end else if (filter_tick) begin
            fixed_freq_clock <= ~fixed_freq_clock;
        end
    end

    // fll runs unless low power bypass outside debug
    assign fll_enabled = ~(second_control_reg.fll_power_down_bit & ~bdm_sync
        & (clock_state_field != 2'b00));

    // lock model: dco period is the filter period over 512; relock on reference change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= 16'h0000;
            dco_period <= 16'h0000;
            lock_cnt <= 32'h0000_0000;
            fll_locked <= 1'b0;
            ref_cfg_prev <= 4'h0;
        end else begin
            ref_cfg_prev <= {first_control_reg.internal_reference_select, first_control_reg.reference_divider};
            period_cnt <= filter_tick ? 16'h0000 : period_cnt + 16'h0001;
            if (filter_tick) dco_period <= (period_cnt + 16'h0001) >> `FLL_MULT_SHIFT;
            if (!fll_enabled || (first_control_reg.internal_reference_select && !irc_stable)
                || ref_cfg_prev != {first_control_reg.internal_reference_select,
                first_control_reg.reference_divider}) begin
                lock_cnt <= 32'h0000_0000;
                fll_locked <= 1'b0;
            end else if (lock_cnt == 32'(ACQUIRE_CYCLES - 1)) begin
                fll_locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 32'h0000_0001;
            end
        end
    end

    // source of the requested mode and whether it can be switched to
    always_comb begin
        target_tick = 1'b0;
        target_avail = 1'b0;
        unique case (sw_target)
            2'b00: begin
                target_tick = filter_tick;
                target_avail = fll_enabled;
            end
            2'b01: begin
                target_tick = irc_tick;
                target_avail = irc_stable;
            end
            2'b10: begin
                target_tick = ext_tick;
                target_avail = ~second_control_reg.external_oscillator_select | oscillator_ready_flag;
            end
            2'b11: begin
                target_tick = 1'b0;
                target_avail = 1'b0;
            end
        endcase
    end

    // mode switch: new source must tick a few times, else the old one stays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_state <= sw_idle;
            sw_target <= 2'b00;
            sw_cnt <= 3'h0;
            clock_state_field <= 2'b00;
        end else begin
            unique case (sw_state)
                sw_idle: begin
                    if (first_control_reg.clock_select_field != clock_state_field
                        && first_control_reg.clock_select_field != 2'b11) begin
                        sw_target <= first_control_reg.clock_select_field;
                        sw_cnt <= 3'h0;
                        sw_state <= sw_wait;
                    end
                end
                sw_wait: begin
                    if (first_control_reg.clock_select_field != sw_target) begin
                        sw_state <= sw_idle;
                    end else if (sw_cnt == `SWITCH_TICKS) begin
                        clock_state_field <= sw_target;
                        sw_state <= sw_idle;
                    end else if (target_tick && target_avail) begin
                        sw_cnt <= sw_cnt + 3'h1;
                    end
                end
            endcase
        end
    end

    assign main_clock_source = clock_state_field;
    assign bus_divider = second_control_reg.bus_divider;

    // fixed frequency valid: engaged always, bypass by divider pairs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fixed_freq_valid <= 1'b1;
        end else if (clock_state_field == 2'b00) begin
            fixed_freq_valid <= 1'b1;
        end else begin
            fixed_freq_valid <= {1'b0, first_control_reg.reference_divider}
                >= ({2'b00, second_control_reg.bus_divider} + {1'b0, `FF_BUS_DIV_OFFSET});
        end
    end

    sequence s_switch_ready;
        sw_state == sw_wait && sw_cnt == `SWITCH_TICKS && first_control_reg.clock_select_field == sw_target;
    endsequence

    property p_ff_engaged;
        @(posedge clk) disable iff (!rst_n) clock_state_field == 2'b00 |=> fixed_freq_valid;
    endproperty
    a_ff_engaged: assert property (p_ff_engaged) else $error("valid low in engaged mode");

    property p_ff_bypass;
        @(posedge clk) disable iff (!rst_n) (clock_state_field != 2'b00 && $stable(first_control_reg)
            && $stable(second_control_reg)) |=> fixed_freq_valid == ({1'b0, $past(first_control_reg.reference_divider)}
            >= {2'b00, $past(second_control_reg.bus_divider)} + 4'h2);
    endproperty
    a_ff_bypass: assert property (p_ff_bypass) else $error("bypass valid wrong");

    property p_ff_toggle;
        @(posedge clk) disable iff (!rst_n) filter_tick |=> fixed_freq_clock != $past(fixed_freq_clock);
    endproperty
    a_ff_toggle: assert property (p_ff_toggle) else $error("fixed clock missed tick");

    property p_lock_needs_irc;
        @(posedge clk) disable iff (!rst_n) (first_control_reg.internal_reference_select && !irc_stable)
            |=> !fll_locked;
    endproperty
    a_lock_needs_irc: assert property (p_lock_needs_irc) else $error("locked before reference stable");

    property p_power_down_off;
        @(posedge clk) disable iff (!rst_n) (second_control_reg.fll_power_down_bit && !bdm_sync
            && clock_state_field == 2'b10) |-> !fll_enabled ##1 !fll_locked;
    endproperty
    a_power_down_off: assert property (p_power_down_off) else $error("fll on in low power bypass");

    property p_switch;
        @(posedge clk) disable iff (!rst_n) s_switch_ready |=> clock_state_field == $past(sw_target);
    endproperty
    a_switch: assert property (p_switch) else $error("clock state not taken after switch");

    property p_no_spurious_state;
        @(posedge clk) disable iff (!rst_n) (sw_state == sw_idle) |=> $stable(clock_state_field);
    endproperty
    a_no_spurious_state: assert property (p_no_spurious_state) else $error("state moved while idle");

    property p_osc_ready;
        @(posedge clk) disable iff (!rst_n) (second_control_reg.external_oscillator_select && external_ref_running
            && osc_cnt == `OSC_INIT_EDGES) |=> oscillator_ready_flag;
    endproperty
    a_osc_ready: assert property (p_osc_ready) else $error("oscillator flag not set");

    property p_irc_kept;
        @(posedge clk) disable iff (!rst_n) first_control_reg.internal_ref_output_enable |-> internal_ref_running;
    endproperty
    a_irc_kept: assert property (p_irc_kept) else $error("internal reference stopped");

    property p_erc_kept;
        @(posedge clk) disable iff (!rst_n) second_control_reg.external_ref_output_enable |-> external_ref_running;
    endproperty
    a_erc_kept: assert property (p_erc_kept) else $error("external reference stopped");

    property p_dco;
        @(posedge clk) disable iff (!rst_n) filter_tick |=> dco_period == (($past(period_cnt) + 16'h0001) >> 9);
    endproperty
    a_dco: assert property (p_dco) else $error("dco ratio wrong");
endmodule

// ==== bench/ext_osc.sv ====
// external crystal model that sits on the reference pin of the clock source unit
// assumes the bench clock and the device's external reference enable as its supply
module ext_osc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic slow,
    output logic ext_ref
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // square wave of 3 or 6 clocks per half period, stands low while not powered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            ext_ref <= 1'b0;
        end else if (!enable) begin
            cnt <= 4'h0;
            ext_ref <= 1'b0;
        end else if (cnt >= (slow ? 4'h5 : 4'h2)) begin
            cnt <= 4'h0;
            ext_ref <= ~ext_ref;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench of the clock source unit: register bus, modes, lock and fixed clock
// assumes the design package and the crystal model; the lock count is shortened to 50
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fll_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    avl_req_t avl_req = '0;
    logic bdm_active = 1'b0;
    logic slow = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, ext_ref_in, fixed_freq_clock, fixed_freq_valid, fll_enabled, fll_locked;
    logic internal_ref_running, external_ref_running;
    clk_sel_t main_clock_source;
    logic [1:0] bus_divider;
    logic [15:0] dco_period;
    int err_total = 0;
    int n_tests = 0;
    int per, i;
    logic [31:0] rd;
    logic [8:0] trimv;
    logic [2:0] r;

    fll_clock_source_control #(.ACQUIRE_CYCLES(50)) fll_clock_source_control_i (.clk, .rst_n, .avl_req,
        .avs_readdata, .avs_waitrequest, .ext_ref_in, .bdm_active, .fixed_freq_clock, .fixed_freq_valid,
        .main_clock_source, .bus_divider, .fll_enabled, .fll_locked, .dco_period, .internal_ref_running,
        .external_ref_running);
    ext_osc ext_osc_i (.clk, .rst_n, .enable(external_ref_running), .slow, .ext_ref(ext_ref_in));

    // 50 ns period
    always #25 clk = ~clk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic timeout(string what);
        err_total++;
        $display("wrong value %s expected done seen timeout", what);
        results();
    endtask

    // one avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(logic wr, logic [3:0] a, logic [7:0] d);
        int k;
        @(posedge clk);
        avl_req <= '{address: a, read: !wr, write: wr, writedata: 32'(d)};
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) timeout("bus");
        rd = avs_readdata;
        avl_req.read <= 1'b0;
        avl_req.write <= 1'b0;
    endtask

    task automatic rdc(string n, logic [3:0] a, logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(n, rd, 32'(exp));
    endtask

    task automatic wait_src(clk_sel_t s);
        int k;
        for (k = 0; k < 8000; k++) begin
            @(negedge clk);
            if (main_clock_source === s) break;
        end
        if (k == 8000) timeout("clock state");
    endtask

    task automatic wait_lock;
        int k;
        for (k = 0; k < 3000; k++) begin
            @(negedge clk);
            if (fll_locked === 1'b1) break;
        end
        if (k == 3000) timeout("lock");
    endtask

    // clocks between two toggles of the fixed clock
    task automatic ff_period(output int n);
        logic v;
        int k;
        @(negedge clk);
        v = fixed_freq_clock;
        for (k = 0; k < 6000 && fixed_freq_clock === v; k++) @(negedge clk);
        if (k == 6000) timeout("fixed clock");
        v = fixed_freq_clock;
        for (n = 0; n < 6000 && fixed_freq_clock === v; n++) @(negedge clk);
        if (n == 6000) timeout("fixed clock");
    endtask

    function automatic logic [7:0] c1(logic [1:0] s, logic [2:0] rdv, logic irs, logic ire);
        return {s, rdv, irs, ire, 1'b0};
    endfunction

    function automatic logic [7:0] c2(logic [1:0] b, logic pd, logic ers, logic ere);
        return {b, 2'b00, pd, ers, ere, 1'b0};
    endfunction

    function automatic logic ffv(logic [1:0] b, logic [2:0] rdv);
        return int'(rdv) >= int'(b) + 2;
    endfunction

    initial begin
        void'($urandom(32'hbfc0));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // power-on state and register defaults, unmapped offset reads zero
        check("source", 32'(main_clock_source), 32'h0000_0000);
        check("divider", 32'(bus_divider), 32'h0000_0001);
        check("ff valid", 32'(fixed_freq_valid), 32'h0000_0001);
        rdc("ctrl1", 4'h0, 8'h04);
        rdc("ctrl2", 4'h4, 8'h40);
        rdc("trim", 4'h8, 8'h80);
        rdc("status", 4'hc, 8'h20);
        rdc("unmapped", 4'h2, 8'h00);
        // software trim load, read-only status bits refuse writes
        trimv = {8'hff, 1'($urandom)};
        bus(1'b1, 4'h8, 8'hff);
        bus(1'b1, 4'hc, {7'h7f, trimv[0]});
        repeat (850) @(negedge clk);
        check("early lock", 32'(fll_locked), 32'h0000_0000);
        wait_lock();
        rdc("status", 4'hc, {7'h18, trimv[0]});
        ff_period(per);
        check("ff period", per, int'(trimv) + 1);
        check("dco", 32'(dco_period), (int'(trimv) + 1) >> 9);
        $display("test reset_trim_lock done");
        // bypass internal with power down, then debug keeps the fll alive
        bus(1'b1, 4'h4, c2(2'b01, 1'b1, 1'b0, 1'b0));
        bus(1'b1, 4'h0, c1(2'b01, 3'h0, 1'b1, 1'b0));
        wait_src(2'b01);
        rdc("state", 4'hc, {7'h02, trimv[0]});
        check("fll off", 32'(fll_enabled), 32'h0000_0000);
        @(posedge clk);
        bdm_active <= 1'b1;
        repeat (6) @(negedge clk);
        check("fll debug", 32'(fll_enabled), 32'h0000_0001);
        @(posedge clk);
        bdm_active <= 1'b0;
        // every bus divider against boundary and random reference dividers
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 3; k++) begin
                r = (k < 2) ? 3'(b + 1 + k) : 3'($urandom_range(7, 0));
                bus(1'b1, 4'h4, c2(2'(b), 1'b1, 1'b0, 1'b0));
                bus(1'b1, 4'h0, c1(2'b01, r, 1'b1, 1'b0));
                repeat (2) @(negedge clk);
                check("divider", 32'(bus_divider), 32'(b));
                check("ff valid", 32'(fixed_freq_valid), 32'(ffv(2'(b), r)));
            end
        end
        $display("test bypass_internal done");
        // enable the crystal first, wait for ready, then select bypass external
        slow <= 1'b1;
        bus(1'b1, 4'h4, c2(2'b01, 1'b1, 1'b1, 1'b1));
        for (i = 0; i < 400; i++) begin
            bus(1'b0, 4'hc, 8'h00);
            if (rd[1] === 1'b1) break;
        end
        if (i == 400) timeout("osc ready");
        check("init wait", 32'(i > 50), 32'h0000_0001);
        bus(1'b1, 4'h0, c1(2'b10, 3'h0, 1'b0, 1'b1));
        wait_src(2'b10);
        check("irc kept", 32'(internal_ref_running), 32'h0000_0001);
        bus(1'b1, 4'h0, c1(2'b10, 3'h0, 1'b0, 1'b0));
        repeat (2) @(negedge clk);
        check("irc off", 32'(internal_ref_running), 32'h0000_0000);
        // engaged external: divider and select in one write
        slow <= 1'b0;
        r = 3'($urandom_range(3, 0));
        bus(1'b1, 4'h4, c2(2'b01, 1'b0, 1'b1, 1'b0));
        bus(1'b1, 4'h0, c1(2'b00, r, 1'b0, 1'b0));
        wait_src(2'b00);
        check("ff valid", 32'(fixed_freq_valid), 32'h0000_0001);
        ff_period(per);
        check("ff period", per, 6 << r);
        $display("test external done");
        // back to engaged internal: state stays, lock restarts after irc startup
        bus(1'b1, 4'h0, c1(2'b00, 3'h0, 1'b1, 1'b0));
        repeat (600) @(negedge clk);
        check("relock early", 32'(fll_locked), 32'h0000_0000);
        check("state kept", 32'(main_clock_source), 32'h0000_0000);
        wait_lock();
        bus(1'b1, 4'h4, c2(2'b01, 1'b1, 1'b0, 1'b1));
        repeat (2) @(negedge clk);
        check("ext kept", 32'(external_ref_running), 32'h0000_0001);
        bus(1'b1, 4'h4, c2(2'b01, 1'b1, 1'b0, 1'b0));
        repeat (2) @(negedge clk);
        check("ext off", 32'(external_ref_running), 32'h0000_0000);
        $display("test internal_return done");
        // reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        check("source", 32'(main_clock_source), 32'h0000_0000);
        check("divider", 32'(bus_divider), 32'h0000_0001);
        @(posedge clk);
        rst_n <= 1'b1;
        rdc("ctrl1", 4'h0, 8'h04);
        $display("test second_reset done");
        results();
    end
endmodule
